// ---- src/lpcs_consts.svh ----
`ifndef LPCS_CONSTS_SVH
`define LPCS_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define LPCS_IDX_LP_CTRL 8'h6E
`define LPCS_IDX_DATA_EN 8'h70
`define LPCS_IDX_VECTOR 8'h71
`define LPCS_IDX_CAL_CTRL 8'h72
`define LPCS_IDX_STATUS 8'h73

// Reset values.
`define LPCS_RST_LP_CTRL 8'h88
`define LPCS_RST_DATA_EN 8'h00
`define LPCS_RST_CAL_CTRL 8'h04

// Field positions of lowpower_calib_control.
`define LPCS_SLEEP_HI 7
`define LPCS_SLEEP_LO 5
`define LPCS_SETTLE_HI 4
`define LPCS_SETTLE_LO 3
`define LPCS_BIT_WAKE_TRIG 1
`define LPCS_BIT_POWER_SAVING_CALIB_ENABLE 0

// Field positions of the calibration control register.
`define LPCS_BIT_BG_EN 0
`define LPCS_BIT_TRIG_SRC 1
`define LPCS_BIT_SOFT_TRIG 2

// Field positions of the status register.
`define LPCS_BIT_STOPPED 0
`define LPCS_BIT_ASLEEP 1
`define LPCS_BIT_SETTLING 2
`define LPCS_BIT_VEC_VALID 3

// Interval exponents for the sleep codes 0 to 7.
`define LPCS_SLEEP_EXP0 6'd3
`define LPCS_SLEEP_EXP1 6'd15
`define LPCS_SLEEP_EXP2 6'd18
`define LPCS_SLEEP_EXP3 6'd21
`define LPCS_SLEEP_EXP4 6'd21
`define LPCS_SLEEP_EXP5 6'd27
`define LPCS_SLEEP_EXP6 6'd30
`define LPCS_SLEEP_EXP7 6'd33

// Interval exponents for the settle codes 0 to 3.
`define LPCS_SETTLE_EXP0 6'd33
`define LPCS_SETTLE_EXP1 6'd18
`define LPCS_SETTLE_EXP2 6'd21
`define LPCS_SETTLE_EXP3 6'd24

// Every interval is a multiple of 256 clock periods.
`define LPCS_UNIT_SHIFT 6'd8

// Calibration vector length in bytes and its last index.
`define LPCS_VEC_LEN 673
`define LPCS_VEC_LAST 10'h2A0

`endif

// ---- src/lpcs_interval_timer.sv ----
`timescale 1ns/1ps

// Down-counter that gives a one-cycle done pulse after a loaded interval.
module lpcs_interval_timer (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Control.
  input wire logic i_load,
  input wire lpcs_pkg::lpcs_count_t i_count,
  // Result.
  output logic o_done
);
  import lpcs_pkg::*;

  lpcs_count_t cnt_reg; // Cycles left in the interval.
  lpcs_count_t cnt_next; // Next value of the remaining count.
  logic done_reg; // Done pulse.
  logic done_next; // Next value of the done pulse.

  // A load restarts the interval; otherwise the count runs down to zero.
  always_comb begin
    done_next = 1'b0;
    if (i_load) begin
      cnt_next = i_count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 42'h1;
      done_next = (cnt_reg == 42'h1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // Registers the counter and the pulse.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;

endmodule

// ---- src/lpcs_pkg.sv ----
package lpcs_pkg;

  // Width of an interval count: (2^33+1)*256 needs 42 bits.
  typedef logic [41:0] lpcs_count_t;

  // Scheduler states of the low-power calibration cycle.
  typedef enum logic [1:0] {
    LPCS_IDLE,
    LPCS_SLEEP,
    LPCS_SETTLE,
    LPCS_CALIB
  } lpcs_state_t;

endpackage

// ---- src/lpcs_scheduler.sv ----
`timescale 1ns/1ps
`include "lpcs_consts.svh"

// What this block does
// - Sleep code sets sleep interval (2^N+1)*256.
// - Settle code sets wake-to-calibration wait.
// - Timed sleep, or wake on trigger low.
// - Power saving acts only with background enabled.
// - Enable bit gates the calibration vector port.
// - Each read returns the next stored byte.
// - Each write loads the next storage byte.
// - Incomplete transfer leaves calibration data invalid.
// - Stopped status follows halt or foreground done.
// - Trigger source picks software bit or pin.
module lpcs_scheduler #(
  parameter int EXP_REDUCE = 0 // Subtracted from every interval exponent to shorten tests.
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Wishbone classic slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Calibration engine and pins.
  input wire logic i_calibration_trigger_pin,
  input wire logic i_fg_done,
  input wire logic i_bg_halted,
  input wire logic i_core_calib_done,
  // Core control.
  output logic o_core_sleep,
  output logic o_core_calib_req,
  output logic o_calib_stopped
);
  import lpcs_pkg::*;

  // Register state.
  logic [7:0] lp_ctrl_reg, lp_ctrl_next; // lowpower_calib_control.
  logic [7:0] data_en_reg, data_en_next; // calib_data_access_enable.
  logic [7:0] cal_ctrl_reg, cal_ctrl_next; // Background enable, trigger source, soft trigger.
  logic [9:0] idx_reg, idx_next; // Calibration vector byte index.
  logic valid_reg, valid_next; // Stored vector is complete.
  logic [31:0] rdat_reg, rdat_next; // Read data register.
  logic ack_reg, ack_next; // Bus acknowledge.
  logic stopped_reg, stopped_next; // Calibration-stopped status.
  logic [7:0] vec_mem [0:`LPCS_VEC_LEN-1]; // Calibration vector storage.
  logic vec_we; // Store one vector byte.

  // Scheduler state.
  lpcs_state_t st_reg, st_next; // Low-power cycle state.
  logic sleep_reg, sleep_next; // Core sleep output.
  logic req_reg, req_next; // Calibration request output.

  // Pin synchronisers.
  logic trig_s1_reg, trig_s2_reg; // Trigger pin stages.
  logic fg_s1_reg, fg_s2_reg; // Foreground done stages.

  // Decoded helpers.
  logic req_new; // A request is waiting for its ack.
  logic commit; // The edge at which the master samples ack.
  logic [7:0] adr_idx; // Register index from the byte address.
  logic lp_active; // Power saving is in force.
  logic trig_eff; // Selected calibration trigger.
  logic t_load; // Restart the interval timer.
  lpcs_count_t t_count; // Interval to load.
  logic t_done; // Interval elapsed.

  // Interval in clock periods for an exponent, optionally shortened.
  function automatic lpcs_count_t interval(input logic [5:0] e);
    logic [5:0] ee;
    ee = (e > 6'(EXP_REDUCE)) ? e - 6'(EXP_REDUCE) : 6'h0;
    interval = ((42'h1 << ee) + 42'h1) << `LPCS_UNIT_SHIFT;
  endfunction

  // Sleep exponent for a sleep code.
  function automatic logic [5:0] sleep_exp(input logic [2:0] c);
    case (c)
      3'h0: sleep_exp = `LPCS_SLEEP_EXP0;
      3'h1: sleep_exp = `LPCS_SLEEP_EXP1;
      3'h2: sleep_exp = `LPCS_SLEEP_EXP2;
      3'h3: sleep_exp = `LPCS_SLEEP_EXP3;
      3'h4: sleep_exp = `LPCS_SLEEP_EXP4;
      3'h5: sleep_exp = `LPCS_SLEEP_EXP5;
      3'h6: sleep_exp = `LPCS_SLEEP_EXP6;
      default: sleep_exp = `LPCS_SLEEP_EXP7;
    endcase
  endfunction

  // Settle exponent for a settle code.
  function automatic logic [5:0] settle_exp(input logic [1:0] c);
    case (c)
      2'h0: settle_exp = `LPCS_SETTLE_EXP0;
      2'h1: settle_exp = `LPCS_SETTLE_EXP1;
      2'h2: settle_exp = `LPCS_SETTLE_EXP2;
      default: settle_exp = `LPCS_SETTLE_EXP3;
    endcase
  endfunction

  assign req_new = i_wb_cyc && i_wb_stb && !ack_reg;
  assign commit = i_wb_cyc && i_wb_stb && ack_reg;
  assign adr_idx = i_wb_adr[9:2];
  assign lp_active = lp_ctrl_reg[`LPCS_BIT_POWER_SAVING_CALIB_ENABLE] && cal_ctrl_reg[`LPCS_BIT_BG_EN];
  assign trig_eff = cal_ctrl_reg[`LPCS_BIT_TRIG_SRC] ? trig_s2_reg
                  : cal_ctrl_reg[`LPCS_BIT_SOFT_TRIG];

  // Interval timer shared by the sleep and settle phases.
  lpcs_interval_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_load(t_load),
    .i_count(t_count),
    .o_done(t_done)
  );

  // Bus decode, register writes and vector port side effects.
  always_comb begin
    lp_ctrl_next = lp_ctrl_reg;
    data_en_next = data_en_reg;
    cal_ctrl_next = cal_ctrl_reg;
    idx_next = idx_reg;
    valid_next = valid_reg;
    rdat_next = rdat_reg;
    ack_next = req_new;
    vec_we = 1'b0;
    // Read data is prepared with the ack; unmapped indices read zero.
    if (req_new) begin
      case (adr_idx)
        `LPCS_IDX_LP_CTRL: rdat_next = {24'h0, lp_ctrl_reg};
        `LPCS_IDX_DATA_EN: rdat_next = {24'h0, data_en_reg};
        `LPCS_IDX_VECTOR: rdat_next = data_en_reg[0] ? {24'h0, vec_mem[idx_reg]} : 32'h0;
        `LPCS_IDX_CAL_CTRL: rdat_next = {24'h0, cal_ctrl_reg};
        `LPCS_IDX_STATUS: begin
          rdat_next = 32'h0;
          rdat_next[`LPCS_BIT_STOPPED] = stopped_reg;
          rdat_next[`LPCS_BIT_ASLEEP] = sleep_reg;
          rdat_next[`LPCS_BIT_SETTLING] = (st_reg == LPCS_SETTLE);
          rdat_next[`LPCS_BIT_VEC_VALID] = valid_reg;
        end
        default: rdat_next = 32'h0;
      endcase
    end
    // Writes and the index step happen at the edge where ack is sampled.
    if (commit) begin
      if (i_wb_we && i_wb_sel[0]) begin
        case (adr_idx)
          `LPCS_IDX_LP_CTRL: lp_ctrl_next = i_wb_dat[7:0];
          `LPCS_IDX_DATA_EN: begin
            data_en_next = i_wb_dat[7:0];
            if (i_wb_dat[0] && !data_en_reg[0]) begin
              idx_next = 10'h0;
            end
          end
          `LPCS_IDX_CAL_CTRL: cal_ctrl_next = i_wb_dat[7:0];
          default: ;
        endcase
      end
      // A vector access moves the index on, reads and writes alike.
      if (adr_idx == `LPCS_IDX_VECTOR && data_en_reg[0] && (!i_wb_we || i_wb_sel[0])) begin
        vec_we = i_wb_we;
        idx_next = (idx_reg == `LPCS_VEC_LAST) ? 10'h0 : idx_reg + 10'h1;
        if (idx_reg == 10'h0) begin
          valid_next = 1'b0;
        end
        if (idx_reg == `LPCS_VEC_LAST) begin
          valid_next = 1'b1;
        end
      end
    end
  end

  // Stopped status: halt report with background on, foreground done otherwise.
  always_comb begin
    stopped_next = cal_ctrl_reg[`LPCS_BIT_BG_EN] ? i_bg_halted : fg_s2_reg;
  end

  // Low-power schedule: sleep, settle, calibrate, sleep again.
  always_comb begin
    st_next = st_reg;
    t_load = 1'b0;
    t_count = interval(sleep_exp(lp_ctrl_reg[`LPCS_SLEEP_HI:`LPCS_SLEEP_LO]));
    if (!lp_active) begin
      st_next = LPCS_IDLE;
    end else begin
      case (st_reg)
        LPCS_IDLE: begin
          st_next = LPCS_SLEEP;
          t_load = 1'b1;
        end
        LPCS_SLEEP: begin
          // Trigger mode ignores the timer and waits for a low trigger.
          if (lp_ctrl_reg[`LPCS_BIT_WAKE_TRIG] ? !trig_eff : t_done) begin
            st_next = LPCS_SETTLE;
            t_load = 1'b1;
            t_count = interval(settle_exp(lp_ctrl_reg[`LPCS_SETTLE_HI:`LPCS_SETTLE_LO]));
          end
        end
        LPCS_SETTLE: begin
          if (t_done) begin
            st_next = LPCS_CALIB;
          end
        end
        LPCS_CALIB: begin
          if (i_core_calib_done) begin
            st_next = LPCS_SLEEP;
            t_load = 1'b1;
          end
        end
        default: st_next = LPCS_IDLE;
      endcase
    end
    sleep_next = (st_next == LPCS_SLEEP);
    req_next = (st_next == LPCS_CALIB);
  end

  // Registers all control state.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lp_ctrl_reg <= `LPCS_RST_LP_CTRL;
      data_en_reg <= `LPCS_RST_DATA_EN;
      cal_ctrl_reg <= `LPCS_RST_CAL_CTRL;
      idx_reg <= 10'h0;
      valid_reg <= 1'b0;
      rdat_reg <= 32'h0;
      ack_reg <= 1'b0;
      stopped_reg <= 1'b0;
      st_reg <= LPCS_IDLE;
      sleep_reg <= 1'b0;
      req_reg <= 1'b0;
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      fg_s1_reg <= 1'b0;
      fg_s2_reg <= 1'b0;
    end else begin
      lp_ctrl_reg <= lp_ctrl_next;
      data_en_reg <= data_en_next;
      cal_ctrl_reg <= cal_ctrl_next;
      idx_reg <= idx_next;
      valid_reg <= valid_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
      stopped_reg <= stopped_next;
      st_reg <= st_next;
      sleep_reg <= sleep_next;
      req_reg <= req_next;
      trig_s1_reg <= i_calibration_trigger_pin;
      trig_s2_reg <= trig_s1_reg;
      fg_s1_reg <= i_fg_done;
      fg_s2_reg <= fg_s1_reg;
    end
  end

  // Vector storage has no reset; its content is undefined until loaded.
  always_ff @(posedge i_sys_clk) begin
    if (vec_we) begin
      vec_mem[idx_reg] <= i_wb_dat[7:0];
    end
  end

  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  assign o_core_sleep = sleep_reg;
  assign o_core_calib_req = req_reg;
  assign o_calib_stopped = stopped_reg;

  // The ack is a single-cycle pulse.
  AST_ACK_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ack_reg |=> !ack_reg) else $error("ack held longer than one cycle");

  AST_LP_GATED: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !lp_active |=> (st_reg == LPCS_IDLE) && !o_core_sleep && !o_core_calib_req)
    else $error("scheduler active without both enables");

  AST_TRIG_HOLDS_SLEEP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_reg == LPCS_SLEEP && lp_ctrl_reg[`LPCS_BIT_WAKE_TRIG] && trig_eff && lp_active)
    |=> st_reg == LPCS_SLEEP) else $error("core woke while trigger high");

  AST_SETTLE_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (st_reg == LPCS_SETTLE && !t_done && lp_active) |=> st_reg == LPCS_SETTLE)
    else $error("calibration started before settle interval");

  AST_PORT_GATED: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (req_new && !i_wb_we && adr_idx == `LPCS_IDX_VECTOR && !data_en_reg[0])
    |=> (o_wb_ack && o_wb_dat == 32'h0)) else $error("vector read while access disabled");

  AST_READ_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (commit && !i_wb_we && adr_idx == `LPCS_IDX_VECTOR && data_en_reg[0]
     && idx_reg != `LPCS_VEC_LAST) |=> idx_reg == $past(idx_reg) + 10'h1)
    else $error("vector index did not advance");

  AST_WRITE_STORE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (commit && i_wb_we && i_wb_sel[0] && adr_idx == `LPCS_IDX_VECTOR && data_en_reg[0])
    |=> vec_mem[$past(idx_reg)] == $past(i_wb_dat[7:0])) else $error("vector byte not stored");

  AST_INDEX_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    $rose(data_en_reg[0]) |-> idx_reg == 10'h0) else $error("index not restarted");

  AST_PARTIAL_INVALID: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (commit && adr_idx == `LPCS_IDX_VECTOR && data_en_reg[0] && idx_reg == 10'h0
     && (!i_wb_we || i_wb_sel[0])) |=> !valid_reg)
    else $error("partial transfer left data valid");

  AST_STOPPED: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (cal_ctrl_reg[`LPCS_BIT_BG_EN] && i_bg_halted)[*2] |-> o_calib_stopped)
    else $error("stopped status missing after halt");

endmodule

// ---- tb/lpcs_scheduler_tb.sv ----
`timescale 1ns/1ps
`include "lpcs_consts.svh"

// Self-checking bench for the low-power calibration scheduler.
module lpcs_scheduler_tb;
  import lpcs_pkg::*;
  // Exponent reduction handed to the design so timed phases stay short.
  localparam int RED = 15;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic trig_pin = 1'b1;
  logic fg_done = 1'b0;
  logic bg_halted = 1'b0;
  logic core_done = 1'b0;
  logic [2:0] outs; // Stopped, calibration request and sleep, in that order.
  int errors = 0;
  int n_checks = 0;

  lpcs_scheduler #(.EXP_REDUCE(RED)) DUT (
    .i_sys_clk(sys_clk), .i_nrst(nrst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_calibration_trigger_pin(trig_pin),
    .i_fg_done(fg_done), .i_bg_halted(bg_halted), .i_core_calib_done(core_done),
    .o_core_sleep(outs[0]), .o_core_calib_req(outs[1]), .o_calib_stopped(outs[2])
  );

  // The 40 MHz system clock.
  always #12.5 sys_clk = ~sys_clk;

  // Prints the verdict and ends the run.
  task end_of_test;
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: got %0h, expected %0h", $time, what, seen, exp);
    end
  endtask

  // One classic Wishbone cycle; the request stands until ack is sampled high at a rising edge.
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] sl, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sl;
    wb_dat <= {24'h000000, wd};
    // Each pass looks at ack as it was sampled by this rising edge.
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    // Read data is taken at the same edge that saw ack, then the request is released.
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      errors++;
      $display("[ERR] %0t bus answer timed out", $time);
      end_of_test;
    end
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, 4'h1, d);
  endtask

  task rdb(input logic [7:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, 4'h1, d);
  endtask

  // Waits, bounded, until the chosen output reaches a level; returns cycles taken.
  // Outputs are looked at on falling edges; the task returns on a rising edge for stimulus.
  task automatic wait_lvl(input int w, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (outs[w] !== lvl && cnt <= bound);
    if (outs[w] !== lvl) begin
      errors++;
      $display("[ERR] %0t output %0d never reached its level", $time, w);
      end_of_test;
    end
    @(posedge sys_clk);
  endtask

  // Checks that the chosen output keeps one level for n cycles.
  task automatic hold(input int w, input logic lvl, input int n, input string what);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge sys_clk);
      if (outs[w] !== lvl) ok = 1'b0;
    end
    // Return on a rising edge so the caller's next stimulus lands there.
    @(posedge sys_clk);
    chk(ok, 1, what);
  endtask

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  // Interval length in cycles for an exponent after the reduction.
  function automatic int ivl(input int e);
    return ((1 << (e - RED)) + 1) * 256;
  endfunction

  // Reset values, status at reset, unmapped space and byte-lane masking.
  task t_regs;
    logic [7:0] d;
    rdb(`LPCS_IDX_LP_CTRL, d);
    chk(d, `LPCS_RST_LP_CTRL, "control reset");
    rdb(`LPCS_IDX_DATA_EN, d);
    chk(d, `LPCS_RST_DATA_EN, "access enable reset");
    rdb(`LPCS_IDX_STATUS, d);
    chk(d, 8'h00, "status reset");
    rdb(8'h10, d);
    chk(d, 8'h00, "unmapped read");
    bus(1'b1, `LPCS_IDX_LP_CTRL, 8'h29, 4'h0, d);
    rdb(`LPCS_IDX_LP_CTRL, d);
    chk(d, `LPCS_RST_LP_CTRL, "masked write");
    wr(`LPCS_IDX_LP_CTRL, 8'hFF);
    rdb(`LPCS_IDX_LP_CTRL, d);
    chk(d, 8'hFF, "control read back");
    wr(`LPCS_IDX_LP_CTRL, 8'h88);
  endtask

  // Full restore, gated and full readout, then an aborted transfer.
  task t_vector;
    logic [7:0] d;
    // Foreground done with background off makes the stopped status read 1.
    fg_done <= 1'b1;
    wr(`LPCS_IDX_DATA_EN, 8'h01);
    rdb(`LPCS_IDX_STATUS, d);
    chk(d[`LPCS_BIT_STOPPED], 1, "stopped before vector access");
    for (int i = 0; i < `LPCS_VEC_LEN; i++) wr(`LPCS_IDX_VECTOR, pat(i));
    rdb(`LPCS_IDX_STATUS, d);
    chk(d[`LPCS_BIT_VEC_VALID], 1, "valid after restore");
    wr(`LPCS_IDX_DATA_EN, 8'h00);
    rdb(`LPCS_IDX_VECTOR, d);
    chk(d, 8'h00, "gated port read");
    wr(`LPCS_IDX_DATA_EN, 8'h01);
    for (int i = 0; i < `LPCS_VEC_LEN; i++) begin
      rdb(`LPCS_IDX_VECTOR, d);
      chk(d, pat(i), "vector byte");
    end
    wr(`LPCS_IDX_DATA_EN, 8'h00);
    wr(`LPCS_IDX_DATA_EN, 8'h01);
    rdb(`LPCS_IDX_VECTOR, d);
    chk(d, pat(0), "index restart");
    rdb(`LPCS_IDX_STATUS, d);
    chk(d[`LPCS_BIT_VEC_VALID], 0, "valid after abort");
    fg_done <= 1'b0;
    wr(`LPCS_IDX_DATA_EN, 8'h00);
  endtask

  // Stopped status follows the halt flag, or foreground completion without background.
  task t_stop;
    int c;
    wr(`LPCS_IDX_CAL_CTRL, 8'h05);
    bg_halted <= 1'b1;
    wait_lvl(2, 1'b1, 4, c);
    bg_halted <= 1'b0;
    wait_lvl(2, 1'b0, 4, c);
    wr(`LPCS_IDX_CAL_CTRL, 8'h04);
    fg_done <= 1'b1;
    wait_lvl(2, 1'b1, 6, c);
    fg_done <= 1'b0;
  endtask

  // Timed mode: gated by background enable, then measured sleep and settle phases.
  task t_timed;
    int c;
    // Sleep code 4 and settle code 1 are the lowest codes software should use.
    wr(`LPCS_IDX_LP_CTRL, 8'h89);
    hold(0, 1'b0, 600, "sleep without background");
    wr(`LPCS_IDX_CAL_CTRL, 8'h05);
    wait_lvl(0, 1'b1, 8, c);
    wait_lvl(0, 1'b0, ivl(`LPCS_SLEEP_EXP4) + 16, c);
    chk(c >= ivl(`LPCS_SLEEP_EXP4) - 8, 1, "sleep interval");
    wait_lvl(1, 1'b1, ivl(`LPCS_SETTLE_EXP1) + 16, c);
    chk(c >= ivl(`LPCS_SETTLE_EXP1) - 8, 1, "settle interval");
    @(posedge sys_clk);
    core_done <= 1'b1;
    @(posedge sys_clk);
    core_done <= 1'b0;
    wait_lvl(0, 1'b1, 4, c);
    @(negedge sys_clk);
    chk(outs[1], 0, "request cleared");
    wr(`LPCS_IDX_LP_CTRL, 8'h88);
    wait_lvl(0, 1'b0, 4, c);
  endtask

  // Trigger mode with the pin as source, then with the software bit as source.
  task t_trig;
    int c;
    wr(`LPCS_IDX_CAL_CTRL, 8'h07);
    wr(`LPCS_IDX_LP_CTRL, 8'h2B);
    wait_lvl(0, 1'b1, 8, c);
    hold(0, 1'b1, 700, "asleep past timed interval");
    wr(`LPCS_IDX_CAL_CTRL, 8'h03);
    hold(0, 1'b1, 20, "software bit ignored");
    trig_pin <= 1'b0;
    wait_lvl(0, 1'b0, 8, c);
    wr(`LPCS_IDX_LP_CTRL, 8'h88);
    trig_pin <= 1'b1;
    wr(`LPCS_IDX_CAL_CTRL, 8'h01);
    wr(`LPCS_IDX_LP_CTRL, 8'h2B);
    wait_lvl(0, 1'b1, 8, c);
    wait_lvl(0, 1'b0, 8, c);
    wr(`LPCS_IDX_LP_CTRL, 8'h88);
  endtask

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_vector;
    t_stop;
    t_timed;
    t_trig;
    end_of_test;
  end
endmodule
